// >>> dv/pfc_board_model.sv
// Purpose: board side of the fan-out block: reference source and feedback trace
// Assumes: reference edges land just after mclk edges
// Notes:   half plus one sets the half period in mclk cycles, changing it mimics spread spectrum
`timescale 1ns/1ps
`default_nettype none
module pfc_board_model
  import pfc_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // source control
  input  wire logic       run,
  input  wire logic [3:0] half,
  // feedback trace
  input  wire logic       fb_out_p,
  input  wire logic       fb_out_n,
  output logic            ref_p,
  output logic            ref_n,
  output logic            fb_in_p,
  output logic            fb_in_n
);
  logic [3:0] cnt;

  // stopped source rests both low, as the input pull-downs would leave it
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt     <= 4'h0;
      ref_p   <= 1'b0;
      ref_n   <= 1'b0;
    end
    else
    begin
      if (!run)
      begin
        cnt   <= 4'h0;
        ref_p <= 1'b0;
        ref_n <= 1'b0;
      end
      else if (cnt >= half)
      begin
        cnt   <= 4'h0;
        ref_p <= !ref_p;
        ref_n <= ref_p;
      end
      else
        cnt <= cnt + 4'h1;
    end
  end
  // short trace: feedback returns the output level in the same cycle
  assign fb_in_p = fb_out_p;
  assign fb_in_n = fb_out_n;
endmodule : pfc_board_model
`default_nettype wire

// >>> dv/test_pfc_top.sv
// Purpose: self-checking bench of the fan-out output control block
// Assumes: zero-wait apb, outputs one cycle behind sampled pins
// Notes:   a negedge monitor compares every pair while chk_on is set
`timescale 1ns/1ps
`default_nettype none
`include "pfc_cfg.svh"
module test_pfc_top
  import pfc_pkg::*;
;
  localparam int LOCK = 8;
  logic mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic ref_p, ref_n, fbi_p, fbi_n, fbo_p, fbo_n, oe = 1, strap = 1, ana = 1, run = 1;
  logic [3:0] half = 4'h1;
  logic [9:0] y_p, y_n, ey_p, ey_n, en, mask_m = 10'h3ff;
  logic efb_p, efb_n, live = 1, chk_on = 0;
  int fail_count = 0, num_checks = 0, cyc = 0;

  always #2.5 mclk = !mclk;

  pfc_top #(.LOCK_CYC(`PFC_CNT_W'(LOCK))) uut (.mclk(mclk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_clk_pair_p(ref_p), .ref_clk_pair_n(ref_n),
    .feedback_in_pair_p(fbi_p), .feedback_in_pair_n(fbi_n), .output_enable(oe),
    .output_select_strap(strap), .analog_supply_pin(ana), .y_p(y_p), .y_n(y_n),
    .feedback_out_pair_p(fbo_p), .feedback_out_pair_n(fbo_n));
  pfc_board_model board (.mclk(mclk), .rstn(rstn), .run(run), .half(half), .fb_out_p(fbo_p),
    .fb_out_n(fbo_n), .ref_p(ref_p), .ref_n(ref_n), .fb_in_p(fbi_p), .fb_in_n(fbi_n));

  // expected pairs from pre-edge pins
  assign en = mask_m & (oe ? 10'h3ff : (strap ? 10'h000 : 10'h080));
  always @(posedge mclk)
  begin
    ey_p  <= (live && ref_p) ? en : 10'h000;
    ey_n  <= (live && ref_n) ? en : 10'h000;
    efb_p <= live && ref_p;
    efb_n <= live && ref_n;
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end
  always @(negedge mclk)
  begin
    if (chk_on)
    begin
      chk("y_p", 32'(ey_p), 32'(y_p));
      chk("y_n", 32'(ey_n), 32'(y_n));
      chk("fb_p", 32'(efb_p), 32'(fbo_p));
      chk("fb_n", 32'(efb_n), 32'(fbo_n));
    end
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no wait limit here: only the bench timeout ends a hung transfer
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] q;
    logic err;
    apb(1'b0, a, 32'h0, q, err);
    chk("rdata", e, q);
    chk("slverr", 32'(ee), 32'(err));
  endtask : rd_chk

  task automatic wait_mode(input logic [1:0] m);
    logic [31:0] q;
    logic err;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `PFC_ADDR_STATUS, 32'h0, q, err);
      n++;
    end
    while (q[1:0] !== m && n < 30);
    chk("mode", 32'(m), 32'(q[1:0]));
  endtask : wait_mode

  // strap only moves while the part is held in reset
  task automatic do_reset(input logic s);
    chk_on = 0;
    mask_m = 10'h3ff;
    rstn  <= 1'b0;
    strap <= s;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    wait_mode(2'd1);
  endtask : do_reset

  // upper write bits are junk and must read back as zero
  task automatic set_cfg(input logic [9:0] m, input logic o);
    logic [31:0] q;
    logic err;
    chk_on = 0;
    apb(1'b1, `PFC_ADDR_CTRL, {22'h3fffff, m}, q, err);
    mask_m = m;
    oe <= o;
    rd_chk(`PFC_ADDR_CTRL, {22'h0, m}, 1'b0);
    rd_chk(`PFC_ADDR_STATUS, {26'h0, 1'b1, strap, o, 3'b101}, 1'b0);
    chk_on = 1;
    repeat (20) @(posedge mclk);
  endtask : set_cfg

  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  initial
  begin
    logic [31:0] q;
    logic err;
    int n;
    do_reset(1'b1);
    rd_chk(`PFC_ADDR_CTRL, 32'h3ff, 1'b0);
    rd_chk(8'h08, 32'h0, 1'b1);
    apb(1'b1, `PFC_ADDR_STATUS, 32'hffffffff, q, err);
    rd_chk(`PFC_ADDR_STATUS, 32'h3d, 1'b0);
    for (int s = 1; s >= 0; s--)
    begin
      if (s == 0)
        do_reset(1'b0);
      for (int k = 0; k < 4; k++)
        set_cfg(k[1] ? 10'h2a5 : 10'h3ff, k[0]);
    end
    half <= 4'h0;
    repeat (20) @(posedge mclk);
    half <= 4'h2;
    set_cfg(10'h17f, 1'b0);
    chk_on = 0;
    ana <= 1'b0;
    wait_mode(2'd3);
    chk_on = 1;
    repeat (20) @(posedge mclk);
    chk_on = 0;
    ana <= 1'b1;
    wait_mode(2'd1);
    run <= 1'b0;
    wait_mode(2'd2);
    live = 0;
    chk_on = 1;
    repeat (20) @(posedge mclk);
    chk_on = 0;
    live = 1;
    // fixed reference phase so the first feedback edge lands inside the window
    half <= 4'h1;
    run <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (fbo_p !== 1'b1 && n < 100);
    chk("lock_wait", 32'h1, 32'((n >= LOCK) && (n <= LOCK + 8)));
    wait_mode(2'd1);
    stop_test();
  end
endmodule : test_pfc_top
`default_nettype wire

// >>> verilog/pfc_cfg.svh
// Purpose: constants for the fan-out output control block
// Assumes: 200 MHz mclk, APB register access with 32-bit data
// Notes:   definitions only
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH

`define PFC_NPAIR        10
`define PFC_Y7_IDX       7
`define PFC_CLK_NS       5
// re-lock wait in ns; the real stabilization figure is board dependent
`define PFC_LOCK_NS      15000
`define PFC_LOCK_CYC     ((`PFC_LOCK_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_CNT_W        16

// register byte addresses
`define PFC_ADDR_CTRL    8'h00
`define PFC_ADDR_STATUS  8'h04

// reset values
`define PFC_MASK_RST     10'h3ff

// status fields
`define PFC_ST_STATE_LSB 0
`define PFC_ST_ANALOG    2
`define PFC_ST_OE        3
`define PFC_ST_STRAP     4
`define PFC_ST_LOCKED    5
`define PFC_ST_FBERR     6

`endif

// >>> verilog/pfc_lock_timer.sv
// Purpose: counts the re-lock wait after the loop is restarted
// Assumes: run stays high for the whole wait
// Notes:   done rises lock_cyc cycles after run rises, drops one cycle after run falls
`timescale 1ns/1ps
`default_nettype none
`include "pfc_cfg.svh"

module pfc_lock_timer
  import pfc_pkg::*;
#(
  parameter logic [`PFC_CNT_W-1:0] LOCK_CYC = `PFC_CNT_W'(`PFC_LOCK_CYC)
)
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  // control
  input  wire logic                  run,
  // result
  output logic                       done,
  output logic [`PFC_CNT_W-1:0]      count
);

  pfc_timer_t t_r;
  pfc_timer_t t_nxt;

  // counter saturates at the end so done holds
  always_comb
  begin
    t_nxt = t_r;
    if (!run)
    begin
      t_nxt.cnt  = '0;
      t_nxt.done = 1'b0;
    end
    else
    begin
      if (t_r.cnt != LOCK_CYC - `PFC_CNT_W'(1))
        t_nxt.cnt = t_r.cnt + `PFC_CNT_W'(1);
      t_nxt.done = (t_r.cnt == LOCK_CYC - `PFC_CNT_W'(1));
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      t_r <= '0;
    else
      t_r <= t_nxt;
  end

  assign done  = t_r.done;
  assign count = t_r.cnt;

endmodule : pfc_lock_timer
`default_nettype wire

// >>> verilog/pfc_pkg.sv
// Purpose: shared types of the fan-out output control block
// Assumes: pfc_cfg.svh supplies the widths
// Notes:   state enum plus the packed state records of both modules
`include "pfc_cfg.svh"

package pfc_pkg;

  typedef enum logic [1:0] {
    PFC_LOCK,
    PFC_RUN,
    PFC_LOWPWR,
    PFC_BYPASS
  } pfc_mode_t;

  typedef struct packed {
    pfc_mode_t                 mode;
    logic [`PFC_NPAIR-1:0]     y_p;
    logic [`PFC_NPAIR-1:0]     y_n;
    logic                      fb_p;
    logic                      fb_n;
    logic [`PFC_NPAIR-1:0]     mask;
    logic                      fb_err;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
  } pfc_state_t;

  typedef struct packed {
    logic [`PFC_CNT_W-1:0]     cnt;
    logic                      done;
  } pfc_timer_t;

endpackage : pfc_pkg

// >>> verilog/pfc_top.sv
// Purpose: output gating, bypass and auto power-down of a 1:10 zero-delay clock fan-out
// Assumes: all pins sampled on mclk; the loop itself is modelled as a straight path
// Notes:   CTRL holds a per-pair software enable, STATUS shows mode and pins
//
// How it works
// - a low output enable stops the fan-out pairs, all ten with the strap high, while the feedback pair and the loop keep running.
// - with the strap high the output enable gates every fan-out pair the same way.
// - with strap and output enable both low, pair seven keeps running while the rest stop.
// - a grounded analog supply turns the loop off and passes the reference straight to the outputs.
// - with the analog supply up, both reference lines low puts the device in low power with every output and the loop off.
// - when the reference returns as a differential clock the loop restarts and locks within the wait.
// - one reference pair drives ten fan-out pairs and one feedback pair; feedback input only sets the error flag.
// - a spread-spectrum reference is followed without dropping out of lock.
// - any disabled pair is driven statically low on both lines.
`timescale 1ns/1ps
`default_nettype none
`include "pfc_cfg.svh"

module pfc_top
  import pfc_pkg::*;
#(
  parameter logic [`PFC_CNT_W-1:0] LOCK_CYC = `PFC_CNT_W'(`PFC_LOCK_CYC)
)
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // reference and feedback inputs
  input  wire logic                  ref_clk_pair_p,
  input  wire logic                  ref_clk_pair_n,
  input  wire logic                  feedback_in_pair_p,
  input  wire logic                  feedback_in_pair_n,
  // control pins
  input  wire logic                  output_enable,
  input  wire logic                  output_select_strap,
  input  wire logic                  analog_supply_pin,
  // clock outputs
  output logic [`PFC_NPAIR-1:0]      y_p,
  output logic [`PFC_NPAIR-1:0]      y_n,
  output logic                       feedback_out_pair_p,
  output logic                       feedback_out_pair_n
);

  pfc_state_t               s_r;
  pfc_state_t               s_nxt;
  logic                     lock_done;
  logic                     both_low;
  logic                     active;
  logic [`PFC_NPAIR-1:0]    pair_en;
  logic [31:0]              status;

  // gate a reference level onto every enabled pair
  function automatic logic [`PFC_NPAIR-1:0] pfc_gate(input logic [`PFC_NPAIR-1:0] en, input logic lvl);
    pfc_gate = en & {`PFC_NPAIR{lvl}};
  endfunction : pfc_gate

  // lock wait runs only while the loop is re-acquiring
  pfc_lock_timer #(
    .LOCK_CYC (LOCK_CYC)
  ) u_lock (
    .mclk  (mclk),
    .rstn  (rstn),
    .run   (s_r.mode == PFC_LOCK),
    .done  (lock_done),
    .count ()
  );

  // detector looks at raw pin levels, not the clock path
  assign both_low = !ref_clk_pair_p && !ref_clk_pair_n;

  // status word
  always_comb
  begin
    status                                  = '0;
    status[`PFC_ST_STATE_LSB +: 2]          = s_r.mode;
    status[`PFC_ST_ANALOG]                  = analog_supply_pin;
    status[`PFC_ST_OE]                      = output_enable;
    status[`PFC_ST_STRAP]                   = output_select_strap;
    status[`PFC_ST_LOCKED]                  = (s_r.mode == PFC_RUN);
    status[`PFC_ST_FBERR]                   = s_r.fb_err;
  end

  // mode, outputs and register access in one next-state process
  always_comb
  begin
    s_nxt = s_r;
    // mode selection: grounded supply wins, then power-down, then lock
    if (!analog_supply_pin)
      s_nxt.mode = PFC_BYPASS;
    else if (both_low)
      s_nxt.mode = PFC_LOWPWR;
    else
    begin
      case (s_r.mode)
        PFC_LOWPWR: s_nxt.mode = PFC_LOCK;
        PFC_BYPASS: s_nxt.mode = PFC_LOCK;
        PFC_LOCK:   if (lock_done) s_nxt.mode = PFC_RUN;
        // reference edges never leave run, so modulated input keeps lock
        default:    s_nxt.mode = PFC_RUN;
      endcase
    end
    active = (s_nxt.mode == PFC_RUN) || (s_nxt.mode == PFC_BYPASS);
    // enable pin taken as is, no synchroniser, as it is an async gate
    for (int i = 0; i < `PFC_NPAIR; i++)
      pair_en[i] = active && s_r.mask[i] &&
                   (output_enable || (!output_select_strap && i == `PFC_Y7_IDX));
    // disabled pairs go low on both lines
    s_nxt.y_p  = pfc_gate(pair_en, ref_clk_pair_p);
    s_nxt.y_n  = pfc_gate(pair_en, ref_clk_pair_n);
    s_nxt.fb_p = active && ref_clk_pair_p;
    s_nxt.fb_n = active && ref_clk_pair_n;
    // feedback must return the output level once locked
    s_nxt.fb_err = (s_r.mode == PFC_RUN) &&
                   ((feedback_in_pair_p != s_r.fb_p) || (feedback_in_pair_n != s_r.fb_n));
    // apb: answer prepared in setup, taken in the single access cycle
    s_nxt.pready = 1'b0;
    if (psel && !penable)
    begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata  = '0;
      if (paddr == `PFC_ADDR_CTRL)
        s_nxt.prdata[`PFC_NPAIR-1:0] = s_r.mask;
      else if (paddr == `PFC_ADDR_STATUS)
        s_nxt.prdata = status;
      else
        s_nxt.pslverr = 1'b1;
    end
    else if (psel && penable && s_r.pready)
    begin
      if (pwrite && paddr == `PFC_ADDR_CTRL)
        s_nxt.mask = pwdata[`PFC_NPAIR-1:0];
      s_nxt.pslverr = 1'b0;
    end
    else
      s_nxt.pslverr = 1'b0;
  end

  // single state register; loop starts by acquiring lock
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_r      <= '0;
      s_r.mode <= PFC_LOCK;
      s_r.mask <= `PFC_MASK_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign y_p                 = s_r.y_p;
  assign y_n                 = s_r.y_n;
  assign feedback_out_pair_p = s_r.fb_p;
  assign feedback_out_pair_n = s_r.fb_n;
  assign prdata              = s_r.prdata;
  assign pready              = s_r.pready;
  assign pslverr             = s_r.pslverr;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_oe_gates_all: assert property (!output_enable && output_select_strap |=> y_p == '0 && y_n == '0)
    else $error("fan-out pair active while output enable low");
  a_fb_keeps_running: assert property (!output_enable && analog_supply_pin && !both_low && s_r.mode == PFC_RUN
    |=> feedback_out_pair_p == $past(ref_clk_pair_p) && feedback_out_pair_n == $past(ref_clk_pair_n))
    else $error("feedback output stopped by output enable");
  a_y7_free_run: assert property (!output_enable && !output_select_strap && s_r.mode == PFC_RUN && analog_supply_pin
    && !both_low && s_r.mask[`PFC_Y7_IDX] |=> y_p[`PFC_Y7_IDX] == $past(ref_clk_pair_p)
    && (y_p & ~(`PFC_NPAIR'(1) << `PFC_Y7_IDX)) == '0)
    else $error("pair seven gating wrong");
  a_bypass_route: assert property (!analog_supply_pin ##1 !analog_supply_pin
    |-> feedback_out_pair_p == $past(ref_clk_pair_p) && s_r.mode == PFC_BYPASS)
    else $error("bypass does not pass reference");
  a_lowpwr_off: assert property (analog_supply_pin && both_low |=> y_p == '0 && y_n == '0
    && !feedback_out_pair_p && !feedback_out_pair_n && s_r.mode == PFC_LOWPWR)
    else $error("outputs alive in low power");
  a_wake_relock: assert property (s_r.mode == PFC_LOWPWR && analog_supply_pin && !both_low
    |=> s_r.mode == PFC_LOCK ##1 (y_p == '0 && !feedback_out_pair_p))
    else $error("wake did not restart lock");
  // same-cycle check: outputs and mode leave the register together when the wait ends
  a_lock_holds_off: assert property (s_r.mode == PFC_LOCK |-> y_p == '0 && y_n == '0
    && !feedback_out_pair_p && !feedback_out_pair_n)
    else $error("outputs on before lock wait ended");
  a_ten_pairs: assert property (output_enable && analog_supply_pin && s_r.mode == PFC_RUN && !both_low
    |=> y_p == ({`PFC_NPAIR{$past(ref_clk_pair_p)}} & $past(s_r.mask)))
    else $error("fan-out pairs do not follow reference");
  a_run_sticks: assert property (s_r.mode == PFC_RUN && analog_supply_pin && !both_low |=> s_r.mode == PFC_RUN)
    else $error("lock lost on reference activity");
  a_pair_static_low: assert property ((y_p & y_n) == '0)
    else $error("pair drives both lines high");
  a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  c_run_reached: cover property (s_r.mode == PFC_LOCK ##1 s_r.mode == PFC_RUN);
  c_y7_only: cover property (s_r.mode == PFC_RUN && !output_enable && !output_select_strap);
  c_power_down: cover property (s_r.mode == PFC_RUN ##1 s_r.mode == PFC_LOWPWR);
  c_bypass: cover property (s_r.mode == PFC_BYPASS && ref_clk_pair_p);

endmodule : pfc_top
`default_nettype wire
